// [phy_reset_map.vh]
// Function
// (R01) Any reset isolates MAC inputs, drives MAC outputs low, tri-states transmitter, resets state.
// (R02) Leaving hardware or power-on reset ends power-down and captures the management address.
// (R03) Leaving reset re-enables modules, loads register defaults, enables transmitter, resyncs PLLs.
// (R04) MAC-side pins are released at most 640 ns after reset is removed.
// (R05) Controller holds the reset pin low at least five reference clocks to reset.
// (R06) Within 16 reference clocks after pin rise the management port is usable.
// (R07) Reset cycle ends when transmit and receive clocks are valid; MAC waits.
// (R08) Hardware and power-on reset never set the software reset bit.
// (R09) Power-on reset lasts about 20 us, then exits like a hardware reset.
// (R10) During power-on reset the reset pin is ignored.
// (R11) Writing one to the software reset bit enters reset for two reference clocks.
// (R12) Software reset does not enter power-down.
// (R13) Completing any reset restores defaults and clears the software reset bit.
// (R14) Leaving software reset keeps the captured management address.
// (R15) Power-down whenever the reset pin is low or the power-down bit is one.
// (R16) Power-down disables functions, zeroes MAC outputs, tri-states transmitter.
// (R17) Power-down by bit keeps registers but returns latching status bits to defaults.
// (R18) Reset and power-down controls are reached only through the management port.
// (R19) PLL lock ends the reset cycle and enables the MAC data interface.
`ifndef PHY_RESET_MAP_VH
`define PHY_RESET_MAP_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ          250
`define REF_PERIOD_NS    40
`define REF_CYCLES       (`REF_PERIOD_NS * `CLK_MHZ / 1000)
`define HW_MIN_LOW_REFS  5
`define HW_MIN_LOW_CYC   (`HW_MIN_LOW_REFS * `REF_CYCLES)
`define EXIT_REFS        16
`define EXIT_CYC         (`EXIT_REFS * `REF_CYCLES)
`define RELEASE_MAX_NS   640
`define RELEASE_MAX_CYC  (`RELEASE_MAX_NS * `CLK_MHZ / 1000)
`define SW_RST_REFS      2
`define SW_RST_CYC       (`SW_RST_REFS * `REF_CYCLES)
`define POR_US           20
`define POR_CYC          (`POR_US * `CLK_MHZ)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CTRL_ADDR        6'h00
`define EXT_CTRL_ADDR    6'h10
`define STATUS_ADDR      6'h11
`define CTRL_SW_RST_BIT  15
`define CTRL_PD_BIT      11
`define EXT_ADDR_LSB     6
`define EXT_ADDR_MSB     10
`define ST_IN_RESET_BIT  0
`define ST_PD_BIT        1
`define ST_MGMT_RDY_BIT  2
`define ST_CYCLE_END_BIT 3
`define ST_LATCH_LOW_BIT  4
`define ST_LATCH_HIGH_BIT 5
`define ST_LATCH_MAX_LSB  8
`define ST_LATCH_MAX_MSB  15
`define LATCH_LOW_RESET   1'b1
`define LATCH_HIGH_RESET  1'b0
`define LATCH_MAX_RESET   8'h00
`define PD_RESET         1'b0

`endif

// [seq_timer.v]
`timescale 1ns/10ps
`default_nettype none
module seq_timer #(
  parameter TW = 13
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          load_i,
  input  wire [TW-1:0] load_val_i,
  output wire          done_o
);
  reg [TW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Down counter, done in the last cycle of the loaded span
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= {TW{1'b0}};
    end else if (load_i) begin
      cnt_q <= load_val_i;
    end else if (cnt_q != {TW{1'b0}}) begin
      cnt_q <= cnt_q - {{(TW-1){1'b0}}, 1'b1};
    end
  end

  assign done_o = (cnt_q == {{(TW-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// [pin_low_filter.v]
`timescale 1ns/10ps
`default_nettype none
module pin_low_filter #(
  parameter CW     = 8,
  parameter [CW-1:0] N = 8'd50
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire in_low_i,
  output reg  held_o
);
  reg [CW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Counts consecutive low cycles, held once N are seen
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !in_low_i) begin
      cnt_q  <= {CW{1'b0}};
      held_o <= 1'b0;
    end else begin
      if (cnt_q != N) begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
      held_o <= (cnt_q == N - {{(CW-1){1'b0}}, 1'b1}) | held_o;
    end
  end
endmodule
`default_nettype wire

// [phy_reset_powerdown_sequencer.v]
`timescale 1ns/10ps
`default_nettype none
`include "phy_reset_map.vh"
module phy_reset_powerdown_sequencer #(
  parameter POR_CYCLES = `POR_CYC,
  parameter TW         = 13
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        hw_reset_pin_low_n_i,
  input  wire [4:0]  phy_addr_strap_i,
  input  wire        pll_lock_i,
  input  wire        link_ok_i,
  input  wire        fault_i,
  input  wire [7:0]  noise_level_i,
  output reg         mac_in_isolate_o,
  output reg         mac_out_enable_o,
  output reg         mac_data_enable_o,
  output reg         twisted_pair_tx_oe_o,
  output reg         modules_enable_o,
  output reg         sm_reset_o,
  output reg         pll_resync_o,
  output reg         power_down_o,
  output reg         mgmt_ready_o,
  output reg  [4:0]  phy_addr_o
);
  // ----------------------------------------------------------------
  // States and timing
  // ----------------------------------------------------------------
  localparam [2:0] ST_POR      = 3'h0;
  localparam [2:0] ST_HW_RST   = 3'h1;
  localparam [2:0] ST_SW_RST   = 3'h2;
  localparam [2:0] ST_EXIT     = 3'h3;
  localparam [2:0] ST_WAIT_PLL = 3'h4;
  localparam [2:0] ST_RUN      = 3'h5;

  // Pin sampling and the output register use two cycles of the release span
  localparam integer  SW_SPAN   = `SW_RST_CYC;
  localparam integer  EXIT_SPAN = ((`EXIT_CYC < `RELEASE_MAX_CYC) ? `EXIT_CYC
                                                                   : `RELEASE_MAX_CYC) - 2;
  localparam integer  LOW_SPAN  = `HW_MIN_LOW_CYC;
  localparam [TW-1:0] POR_LOAD  = POR_CYCLES[TW-1:0];
  localparam [TW-1:0] SW_LOAD   = SW_SPAN[TW-1:0];
  localparam [TW-1:0] EXIT_LOAD = EXIT_SPAN[TW-1:0]; // R04 R06
  localparam [7:0]    HW_LOW_N  = LOW_SPAN[7:0];

  reg  [2:0]    state_q;
  reg  [2:0]    state_d;
  reg           load;
  reg  [TW-1:0] load_val;
  reg           capture_q;
  reg           capture_d;
  wire          timer_done;
  wire          pin_held;
  wire          pin_low;

  reg           pd_bit_q;
  reg           sw_bit_q;
  reg           latch_low_q;
  reg           latch_high_q;
  reg  [7:0]    latch_max_q;
  reg  [4:0]    addr_q;
  reg           pll_seen_q;
  reg           por_armed_q;

  wire          in_reset;
  wire          reset_pd;
  wire          pd_now;
  wire          port_open;
  wire          bus_req;
  wire          wr_ctrl;
  wire          rd_status;
  wire          sw_req;
  wire          pd_rise;
  reg  [31:0]   rd_data;
  reg  [7:0]    latch_max_base;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign pin_low   = !hw_reset_pin_low_n_i && (state_q != ST_POR); // R10
  assign in_reset  = (state_q == ST_POR) || (state_q == ST_HW_RST) || (state_q == ST_SW_RST);
  assign reset_pd  = (state_q == ST_POR) || (state_q == ST_HW_RST); // R12
  assign pd_now    = pin_low || pd_bit_q || reset_pd; // R15
  assign port_open = (state_q == ST_WAIT_PLL) || (state_q == ST_RUN); // R06 R18
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl   = bus_req && wb_we_i && (wb_adr_i[7:2] == `CTRL_ADDR)
                     && wb_sel_i[1] && port_open;
  assign rd_status = bus_req && !wb_we_i && (wb_adr_i[7:2] == `STATUS_ADDR);
  assign sw_req    = wr_ctrl && wb_dat_i[`CTRL_SW_RST_BIT]; // R11
  assign pd_rise   = wr_ctrl && wb_dat_i[`CTRL_PD_BIT] && !pd_bit_q;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  seq_timer #(
    .TW (TW)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (load),
    .load_val_i (load_val),
    .done_o     (timer_done)
  );

  pin_low_filter #(
    .CW (8),
    .N  (HW_LOW_N)
  ) u_pin_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .in_low_i (pin_low),
    .held_o   (pin_held)
  );

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_d   = state_q;
    load      = 1'b0;
    load_val  = EXIT_LOAD;
    capture_d = capture_q;
    case (state_q)
      ST_POR: begin
        if (!por_armed_q) begin
          load      = 1'b1; // R09
          load_val  = POR_LOAD;
        end else if (timer_done) begin
          state_d   = ST_EXIT; // R09
          load      = 1'b1;
          capture_d = 1'b1;
        end
      end
      ST_HW_RST: begin
        if (hw_reset_pin_low_n_i) begin
          state_d   = ST_EXIT;
          load      = 1'b1;
          capture_d = 1'b1;
        end
      end
      ST_SW_RST: begin
        if (pin_held) begin
          state_d   = ST_HW_RST;
        end else if (timer_done) begin
          state_d   = ST_EXIT;
          load      = 1'b1;
          capture_d = 1'b0; // R14
        end
      end
      ST_EXIT: begin
        if (pin_held) begin
          state_d = ST_HW_RST;
        end else if (timer_done) begin
          state_d = ST_WAIT_PLL; // R04
        end
      end
      ST_WAIT_PLL: begin
        if (pin_held) begin
          state_d = ST_HW_RST;
        end else if (sw_req) begin
          state_d  = ST_SW_RST;
          load     = 1'b1;
          load_val = SW_LOAD;
        end else if (pll_lock_i) begin
          state_d = ST_RUN; // R07 R19
        end
      end
      ST_RUN: begin
        if (pin_held) begin
          state_d = ST_HW_RST;
        end else if (sw_req) begin
          state_d  = ST_SW_RST;
          load     = 1'b1;
          load_val = SW_LOAD;
        end else if (!pll_lock_i) begin
          state_d = ST_WAIT_PLL;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= ST_POR;
      capture_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      capture_q <= capture_d;
    end
  end

  // ----------------------------------------------------------------
  // Power-on timer, armed in the first cycle after reset release
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      por_armed_q <= 1'b0;
    end else begin
      por_armed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Address capture
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= 5'h00;
    end else if ((state_q == ST_EXIT) && capture_q) begin
      addr_q <= phy_addr_strap_i; // R02
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      pd_bit_q <= `PD_RESET;
      sw_bit_q <= 1'b0;
    end else if (in_reset) begin
      pd_bit_q <= `PD_RESET; // R03 R13
      sw_bit_q <= (state_d == ST_SW_RST); // R08 R13
    end else begin
      if (wr_ctrl) begin
        pd_bit_q <= wb_dat_i[`CTRL_PD_BIT];
      end
      sw_bit_q <= sw_req; // R11
    end
  end

  // ----------------------------------------------------------------
  // Latching status bits
  // ----------------------------------------------------------------
  always @* begin
    latch_max_base = rd_status ? `LATCH_MAX_RESET : latch_max_q;
  end

  always @(posedge clk_i) begin
    if (rst_i || in_reset || pd_bit_q || pd_rise) begin
      latch_low_q  <= `LATCH_LOW_RESET; // R01 R17
      latch_high_q <= `LATCH_HIGH_RESET;
      latch_max_q  <= `LATCH_MAX_RESET;
    end else begin
      latch_low_q  <= (rd_status ? 1'b1 : latch_low_q) & link_ok_i;
      latch_high_q <= (rd_status ? 1'b0 : latch_high_q) | fault_i;
      latch_max_q  <= (noise_level_i > latch_max_base) ? noise_level_i : latch_max_base;
    end
  end

  // ----------------------------------------------------------------
  // Reset cycle end flag
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      pll_seen_q <= 1'b0;
    end else if (state_q == ST_RUN) begin
      pll_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i[7:2])
      `CTRL_ADDR: begin
        rd_data[`CTRL_SW_RST_BIT] = sw_bit_q;
        rd_data[`CTRL_PD_BIT]     = pd_bit_q;
      end
      `EXT_CTRL_ADDR: begin
        rd_data[`EXT_ADDR_MSB:`EXT_ADDR_LSB] = addr_q;
      end
      `STATUS_ADDR: begin
        rd_data[`ST_IN_RESET_BIT]           = in_reset;
        rd_data[`ST_PD_BIT]                 = pd_now;
        rd_data[`ST_MGMT_RDY_BIT]           = port_open;
        rd_data[`ST_CYCLE_END_BIT]          = pll_seen_q;
        rd_data[`ST_LATCH_LOW_BIT]                  = latch_low_q;
        rd_data[`ST_LATCH_HIGH_BIT]                 = latch_high_q;
        rd_data[`ST_LATCH_MAX_MSB:`ST_LATCH_MAX_LSB] = latch_max_q;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and module controls
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      mac_in_isolate_o     <= 1'b1;
      mac_out_enable_o     <= 1'b0;
      mac_data_enable_o    <= 1'b0;
      twisted_pair_tx_oe_o <= 1'b0;
      modules_enable_o     <= 1'b0;
      sm_reset_o           <= 1'b1;
      pll_resync_o         <= 1'b0;
      power_down_o         <= 1'b1;
      mgmt_ready_o         <= 1'b0;
      phy_addr_o           <= 5'h00;
    end else begin
      mac_in_isolate_o     <= !port_open || pd_now; // R01 R16
      mac_out_enable_o     <= port_open && !pd_now; // R01 R04 R16
      mac_data_enable_o    <= (state_q == ST_RUN) && pll_lock_i && !pd_now; // R07 R19
      twisted_pair_tx_oe_o <= port_open && !pd_now; // R01 R03 R16
      modules_enable_o     <= !in_reset && !pd_now; // R03 R16
      sm_reset_o           <= in_reset || !por_armed_q; // R01
      pll_resync_o         <= (state_q == ST_EXIT) && (state_d == ST_WAIT_PLL); // R03
      power_down_o         <= pd_now; // R15
      mgmt_ready_o         <= port_open; // R06
      phy_addr_o           <= addr_q;
    end
  end

endmodule
`default_nettype wire

// [phy_seq_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_seq_assertions #(
  parameter POR_CYCLES = 20
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        hw_reset_pin_low_n_i,
  input wire logic        pll_lock_i,
  input wire logic        mac_in_isolate_o,
  input wire logic        mac_out_enable_o,
  input wire logic        mac_data_enable_o,
  input wire logic        twisted_pair_tx_oe_o,
  input wire logic        sm_reset_o,
  input wire logic        power_down_o,
  input wire logic        mgmt_ready_o,
  input wire logic [4:0]  phy_addr_o
);
  // --------
  // Helpers
  // --------
  logic rdy_seen_q;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      rdy_seen_q <= 1'b0;
    else if (mgmt_ready_o)
      rdy_seen_q <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_sw_wr;
    s_take and (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1] && wb_dat_i[15]
      && !wb_dat_i[11] && mgmt_ready_o);
  endsequence

  // --------
  // Properties
  // --------
  property p_ack;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_reset_iso;
    sm_reset_o |-> mac_in_isolate_o && !mac_out_enable_o && !twisted_pair_tx_oe_o
      && !mac_data_enable_o;
  endproperty
  property p_pin_pd;
    mgmt_ready_o && !hw_reset_pin_low_n_i |=> power_down_o;
  endproperty
  property p_pd_out;
    power_down_o [*2] |-> !mac_out_enable_o && !twisted_pair_tx_oe_o && !mac_data_enable_o;
  endproperty
  property p_exit;
    rdy_seen_q && sm_reset_o && $rose(hw_reset_pin_low_n_i)
      |-> ##[1:160] (mgmt_ready_o && mac_out_enable_o);
  endproperty
  property p_no_lock;
    !pll_lock_i [*2] |=> !mac_data_enable_o;
  endproperty
  property p_lock_on;
    $rose(pll_lock_i) && mgmt_ready_o && !power_down_o |-> ##[1:3] mac_data_enable_o;
  endproperty
  property p_sw_enter;
    s_sw_wr |-> ##[1:3] sm_reset_o;
  endproperty
  property p_sw_no_pd;
    s_sw_wr |=> !power_down_o [*8];
  endproperty
  property p_addr_keep;
    sm_reset_o && !power_down_o |-> $stable(phy_addr_o);
  endproperty

  a_ack:       assert property (p_ack) else $error("ack not a single pulse");
  a_reset_iso: assert property (p_reset_iso) else $error("MAC side not isolated");
  a_pin_pd:    assert property (p_pin_pd) else $error("pin low without power-down");
  a_pd_out:    assert property (p_pd_out) else $error("outputs live in power-down");
  a_exit:      assert property (p_exit) else $error("exit too slow");
  a_no_lock:   assert property (p_no_lock) else $error("data enabled without lock");
  a_lock_on:   assert property (p_lock_on) else $error("lock did not enable data");
  a_sw_enter:  assert property (p_sw_enter) else $error("soft reset not entered");
  a_sw_no_pd:  assert property (p_sw_no_pd) else $error("soft reset powered down");
  a_addr_keep: assert property (p_addr_keep) else $error("address changed");
endmodule

bind phy_reset_powerdown_sequencer phy_seq_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .hw_reset_pin_low_n_i, .pll_lock_i, .mac_in_isolate_o, .mac_out_enable_o,
  .mac_data_enable_o, .twisted_pair_tx_oe_o, .sm_reset_o, .power_down_o, .mgmt_ready_o,
  .phy_addr_o);
`default_nettype wire

// [pll_lock_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pll_lock_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pll_resync_i,
  input  wire logic sm_reset_i,
  input  wire logic slow_i,
  output var  logic pll_lock_o
);
  logic [7:0] cnt_q;
  // Lock lost in reset, regained some cycles after resync
  always_ff @(posedge clk_i) begin
    if (rst_i || sm_reset_i) begin
      cnt_q      <= 8'h00;
      pll_lock_o <= 1'b0;
    end else if (pll_resync_i) begin
      cnt_q <= slow_i ? 8'h40 : 8'h04;
    end else if (cnt_q != 8'h00) begin
      cnt_q      <= cnt_q - 8'h01;
      pll_lock_o <= (cnt_q == 8'h01);
    end
  end
endmodule
`default_nettype wire

// [tb_phy_reset_powerdown_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_phy_reset_powerdown_sequencer;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, noise_level_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        hw_reset_pin_low_n_i, pll_lock_i, link_ok_i, fault_i, slow;
  logic [4:0]  phy_addr_strap_i, phy_addr_o;
  logic        mac_in_isolate_o, mac_out_enable_o, mac_data_enable_o, twisted_pair_tx_oe_o;
  logic        modules_enable_o, sm_reset_o, pll_resync_o, power_down_o, mgmt_ready_o;
  int          n_mismatch = 0;
  int          comparisons = 0;

  phy_reset_powerdown_sequencer #(.POR_CYCLES(100)) uut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .hw_reset_pin_low_n_i, .phy_addr_strap_i, .pll_lock_i,
    .link_ok_i, .fault_i, .noise_level_i, .mac_in_isolate_o, .mac_out_enable_o,
    .mac_data_enable_o, .twisted_pair_tx_oe_o, .modules_enable_o, .sm_reset_o,
    .pll_resync_o, .power_down_o, .mgmt_ready_o, .phy_addr_o);

  pll_lock_model u_pll (.clk_i, .rst_i, .pll_resync_i(pll_resync_o),
    .sm_reset_i(sm_reset_o), .slow_i(slow), .pll_lock_o(pll_lock_i));

  // --------
  // Helpers
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      n_mismatch++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic wait_rdy(output int n);
    n = 0;
    while (mgmt_ready_o !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
      n_mismatch++;
  endtask

  task automatic pin_low(input int n);
    hw_reset_pin_low_n_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_por;
    int n;
    repeat (20) @(posedge clk_i);
    pin_low(60);
    hw_reset_pin_low_n_i <= 1'b1;
    wait_rdy(n);
    chk(n + 80 >= 255 && n + 80 <= 268, 1);
    chk(phy_addr_o, 5'h13);
    rdchk(8'h40, 32'h7c0, 32'h4c0);
    rdchk(8'h00, 32'h8000, 0);
    repeat (10) @(posedge clk_i);
    chk(mac_data_enable_o, 1);
    rdchk(8'h44, 32'h8, 32'h8);
  endtask

  task automatic t_hw;
    int n;
    phy_addr_strap_i <= 5'h0b;
    pin_low(20);
    chk(power_down_o, 1);
    hw_reset_pin_low_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk({sm_reset_o, mgmt_ready_o, phy_addr_o}, 7'h33);
    slow <= 1'b1;
    pin_low(60);
    chk({sm_reset_o, mac_in_isolate_o, twisted_pair_tx_oe_o}, 3'h6);
    rdchk(8'h00, 32'h8000, 0);
    hw_reset_pin_low_n_i <= 1'b1;
    wait_rdy(n);
    chk(n <= 161, 1);
    chk(phy_addr_o, 5'h0b);
    rdchk(8'h00, 32'h8800, 0);
    repeat (10) @(posedge clk_i);
    chk(mac_data_enable_o, 0);
    repeat (70) @(posedge clk_i);
    chk(mac_data_enable_o, 1);
  endtask

  task automatic t_sw;
    int n;
    logic [31:0] q;
    slow <= 1'b0;
    phy_addr_strap_i <= 5'h15;
    wr(8'h00, 32'h8000);
    repeat (3) @(posedge clk_i);
    chk({sm_reset_o, power_down_o}, 2'h2);
    q = 32'h8000;
    for (n = 0; n < 40 && q[15] !== 1'b0; n++)
      wb(1'b0, 8'h00, 0, q);
    chk(n > 1, 1);
    chk(q[15], 0);
    wait_rdy(n);
    chk(phy_addr_o, 5'h0b);
  endtask

  task automatic t_pd;
    fault_i <= 1'b1;
    link_ok_i <= 1'b0;
    noise_level_i <= 8'h5a;
    repeat (4) @(posedge clk_i);
    fault_i <= 1'b0;
    link_ok_i <= 1'b1;
    wr(8'h00, 32'h0800);
    repeat (3) @(posedge clk_i);
    chk({power_down_o, mac_out_enable_o, twisted_pair_tx_oe_o, modules_enable_o}, 4'h8);
    rdchk(8'h44, 32'hff30, 32'h10);
    rdchk(8'h00, 32'h0800, 32'h0800);
    rdchk(8'h40, 32'h7c0, 32'h2c0);
    rdchk(8'hfc, 32'hffffffff, 0);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({power_down_o, modules_enable_o}, 2'h1);
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #40000;
    n_mismatch++;
    conclude;
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, fault_i, slow} = 5'h0;
    {wb_adr_i, noise_level_i, wb_sel_i, wb_dat_i} = 52'h0;
    hw_reset_pin_low_n_i = 1'b1;
    link_ok_i = 1'b1;
    phy_addr_strap_i = 5'h13;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por;
    t_hw;
    t_sw;
    t_pd;
    conclude;
  end
endmodule
`default_nettype wire
